//--- src/peq_consts.vh
// constants of the prioritized event queue dispatcher
// assumes: included by the dispatcher only, no process here
// How it works
// - each group serves its queue oldest first; staged events enter it by rank
// - only one service routine active at once
// - running routine is never preempted
// - events during a routine wait in queue
// - queue depths: comm 4/8, io 16, timed 8
// - full queue drops event, sets overflow bit
// - overflow bits clear on return to main
// - three groups; timed events 10,11,21,22 ranked
// - comm events 8,9,23 then 24,25,26
// - io ranks: 19,20, rising then falling edges
// - fast counter events fill io ranks 10-23
// - timed events queue while interrupts disabled
`ifndef PEQ_CONSTS_VH
`define PEQ_CONSTS_VH

// queue depths
`define PEQ_COMM_DEPTH_SMALL 4
`define PEQ_COMM_DEPTH_LARGE 8
`define PEQ_IO_DEPTH 16
`define PEQ_TIMED_DEPTH 8

// event numbering
`define PEQ_EVT_COUNT 34
`define PEQ_EVT_W 6
`define PEQ_SRC_MAX 24

// group codes, highest priority first
`define PEQ_GRP_COMM 2'h0
`define PEQ_GRP_IO 2'h1
`define PEQ_GRP_TIMED 2'h2

// sources per group
`define PEQ_COMM_SRCS 6
`define PEQ_IO_SRCS 24
`define PEQ_TIMED_SRCS 4

// event number per rank slot, slot 0 in the low six bits
`define PEQ_COMM_MAP {6'h1A, 6'h19, 6'h18, 6'h17, 6'h09, 6'h08}
`define PEQ_IO_MAP {6'h21, 6'h1F, 6'h1E, 6'h1D, 6'h20, 6'h12, 6'h11, \
  6'h10, 6'h0F, 6'h0E, 6'h0D, 6'h1C, 6'h1B, 6'h0C, 6'h07, 6'h05, 6'h03, \
  6'h01, 6'h06, 6'h04, 6'h02, 6'h00, 6'h14, 6'h13}
`define PEQ_TIMED_MAP {6'h16, 6'h15, 6'h0B, 6'h0A}

// overflow status byte bit positions
`define PEQ_OVF_COMM_BIT 0
`define PEQ_OVF_IO_BIT 1
`define PEQ_OVF_TIMED_BIT 2
`define PEQ_OVF_RESET 8'h00

`endif

//--- src/peq_fifo.v
// one priority group's event queue, first in first out
// a push while full and a pop while empty are ignored
`timescale 1ns/100ps
module peq_fifo #(
  parameter WIDTH = 6,
  parameter DEPTH = 8
) (
  // clock and control
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  // write side
  input wire wr_en,
  input wire [WIDTH-1:0] wr_data,
  output wire full,
  // read side, data valid the cycle after rd_en
  input wire rd_en,
  output reg [WIDTH-1:0] rd_data_r,
  output wire empty
);
  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam CW = $clog2(DEPTH + 1);
  localparam integer LAST_I = DEPTH - 1;
  localparam integer FULL_I = DEPTH;
  localparam [AW-1:0] LAST = LAST_I[AW-1:0];
  localparam [CW-1:0] FULL_CNT = FULL_I[CW-1:0];

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [CW-1:0] cnt_r;
  wire do_wr;
  wire do_rd;

  assign full = (cnt_r == FULL_CNT);
  assign empty = (cnt_r == {CW{1'b0}});
  assign do_wr = ce & wr_en & ~full;
  assign do_rd = ce & rd_en & ~empty;

  always @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr_r] <= wr_data;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      cnt_r <= {CW{1'b0}};
      rd_data_r <= {WIDTH{1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_r <= (wr_ptr_r == LAST) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_data_r <= mem[rd_ptr_r];
        rd_ptr_r <= (rd_ptr_r == LAST) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      end
      if (do_wr & ~do_rd) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (do_rd & ~do_wr) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // peq_fifo

//--- src/peq_dispatch.v
// event queue dispatcher: stages source pulses, queues them per
// priority group and hands one service routine at a time to the core
// assumes: sources pulse one cycle per event, core pulses isr_done once
// per started routine, all inputs synchronous to clk_sys
// limitation: an arrival meeting a full queue is dropped even when that
// queue is popped in the same cycle
`timescale 1ns/100ps
`include "peq_consts.vh"
module peq_dispatch #(
  parameter COMM_DEPTH = `PEQ_COMM_DEPTH_SMALL,
  parameter IO_DEPTH = `PEQ_IO_DEPTH,
  parameter TIMED_DEPTH = `PEQ_TIMED_DEPTH
) (
  // clock, reset, clock enable
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  // event sources, bit n is event number n
  input wire [`PEQ_EVT_COUNT-1:0] evt_in,
  // processor core
  input wire irq_enable,
  input wire isr_done,
  output reg isr_start_r,
  output wire isr_active,
  output reg [`PEQ_EVT_W-1:0] isr_event_r,
  output reg [1:0] isr_group_r,
  // overflow status byte
  output wire [7:0] ovf_status
);
  localparam NG = 3;
  localparam SM = `PEQ_SRC_MAX;
  localparam EW = `PEQ_EVT_W;

  // routine states: fetch is the cycle in which the popped entry lands
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_FETCH = 2'h1;
  localparam [1:0] ST_ACTIVE = 2'h2;

  // slot maps padded to the widest group
  localparam [SM*EW-1:0] MAP_COMM =
    {{((SM - `PEQ_COMM_SRCS) * EW){1'b0}}, `PEQ_COMM_MAP};
  localparam [SM*EW-1:0] MAP_IO = `PEQ_IO_MAP;
  localparam [SM*EW-1:0] MAP_TIMED =
    {{((SM - `PEQ_TIMED_SRCS) * EW){1'b0}}, `PEQ_TIMED_MAP};
  localparam [7:0] OVF_RST = `PEQ_OVF_RESET;

  // index of the lowest set bit, ties between same-cycle arrivals go
  // to the better rank
  function [4:0] first_set;
    input [SM-1:0] v;
    integer k;
    begin
      first_set = 5'h00;
      for (k = SM - 1; k >= 0; k = k - 1) begin
        if (v[k]) begin
          first_set = k[4:0];
        end
      end
    end
  endfunction

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [2:0] ovf_r;
  reg [2:0] ovf_nxt;
  // staging holds one bit per source slot, per group
  reg [SM*NG-1:0] pend_r;
  reg [NG-1:0] rd_en;
  reg [1:0] pick;
  wire [SM*NG-1:0] src;
  wire [SM*NG-1:0] pend_nxt;
  wire [NG-1:0] q_full;
  wire [NG-1:0] q_empty;
  wire [NG-1:0] drop;
  wire [NG*EW-1:0] q_data;
  wire any_queued;
  wire all_idle;
  wire launch;
  wire ret_main;
  wire in_fetch;
  wire [EW-1:0] head;

  genvar g;
  genvar i;
  generate
    for (g = 0; g < NG; g = g + 1) begin : grp
      localparam [SM*EW-1:0] MAP = (g == 0) ? MAP_COMM :
                                   (g == 1) ? MAP_IO : MAP_TIMED;
      localparam NSRC = (g == 0) ? `PEQ_COMM_SRCS :
                        (g == 1) ? `PEQ_IO_SRCS : `PEQ_TIMED_SRCS;
      localparam DEPTH = (g == 0) ? COMM_DEPTH :
                         (g == 1) ? IO_DEPTH : TIMED_DEPTH;
      wire [SM-1:0] pend;
      wire [SM-1:0] sel_hot;
      wire [4:0] sel;
      wire has;
      wire [EW-1:0] wr_num;

      // spare slots tie low so the padding never stages an event
      for (i = 0; i < SM; i = i + 1) begin : slot
        if (i < NSRC) begin : used
          assign src[g*SM+i] = evt_in[MAP[i*EW +: EW]];
        end else begin : spare
          assign src[g*SM+i] = 1'b0;
        end
      end

      assign pend = pend_r[g*SM +: SM];
      assign has = |pend;
      assign sel = first_set(pend);
      assign sel_hot = {{(SM-1){1'b0}}, has} << sel;
      assign wr_num = MAP[sel*EW +: EW];
      // staged bit leaves when moved on; a fresh arrival wins the clear
      assign pend_nxt[g*SM +: SM] = (pend & ~sel_hot) | src[g*SM +: SM];
      // queueing never looks at irq_enable or the routine state
      assign drop[g] = has & q_full[g];

      peq_fifo #(
        .WIDTH(EW),
        .DEPTH(DEPTH)
      ) u_queue (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .wr_en(has),
        .wr_data(wr_num),
        .full(q_full[g]),
        .rd_en(rd_en[g]),
        .rd_data_r(q_data[g*EW +: EW]),
        .empty(q_empty[g])
      );
    end
  endgenerate

  assign any_queued = ~&q_empty;
  assign all_idle = (&q_empty) & ~(|pend_r);
  assign in_fetch = (state_r == ST_FETCH);
  // start only from idle, so no second routine can overlap
  assign launch = (state_r == ST_IDLE) & irq_enable & any_queued;
  // return to main: routine ended, nothing queued or staged anywhere
  assign ret_main = (state_r == ST_ACTIVE) & isr_done & all_idle;
  // head entry of the chosen group, read data of the last pop
  assign head = q_data[isr_group_r*EW +: EW];
  assign isr_active = (state_r == ST_FETCH) | (state_r == ST_ACTIVE);
  // byte layout: bit 0 comm, bit 1 io, bit 2 timed, the rest zero
  assign ovf_status = {5'h00, ovf_r[`PEQ_OVF_TIMED_BIT],
                       ovf_r[`PEQ_OVF_IO_BIT], ovf_r[`PEQ_OVF_COMM_BIT]};

  // group choice: comm before io before timed
  always @* begin
    if (!q_empty[0]) begin
      pick = `PEQ_GRP_COMM;
    end else if (!q_empty[1]) begin
      pick = `PEQ_GRP_IO;
    end else begin
      pick = `PEQ_GRP_TIMED;
    end
  end

  always @* begin
    state_nxt = state_r;
    rd_en = {NG{1'b0}};
    case (state_r)
      ST_IDLE: begin
        if (launch) begin
          rd_en[pick] = 1'b1;
          state_nxt = ST_FETCH;
        end
      end
      ST_FETCH: begin
        // popped entry lands in the queue's read register
        state_nxt = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        // nothing but the core's done ends a routine, whatever arrives
        if (isr_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // overflow: set wins over the return-to-main clear
  always @* begin
    ovf_nxt = ovf_r;
    if (ret_main) begin
      ovf_nxt = 3'h0;
    end
    ovf_nxt = ovf_nxt | drop;
  end

  // clock enable low freezes staging, queues and routine state
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      pend_r <= {(SM*NG){1'b0}};
      ovf_r <= OVF_RST[2:0];
    end else if (ce) begin
      state_r <= state_nxt;
      pend_r <= pend_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  // start pulses for one cycle; group loads at launch and event at fetch, and both hold until the next routine
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      isr_start_r <= 1'b0;
      isr_event_r <= {EW{1'b0}};
      isr_group_r <= 2'h0;
    end else if (ce) begin
      isr_start_r <= in_fetch;
      if (launch) begin
        isr_group_r <= pick;
      end
      if (in_fetch) begin
        isr_event_r <= head;
      end
    end
  end
endmodule // peq_dispatch

//--- verification/peq_dispatch_monitor.sv
// port checker for the event queue dispatcher
// assumes: bound to peq_dispatch, one clock, clock enable low only in idle
`timescale 1ns/100ps
module peq_dispatch_monitor (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // core side
  input wire irq_enable,
  input wire isr_done,
  input wire isr_start_r,
  input wire isr_active,
  input wire [5:0] isr_event_r,
  input wire [1:0] isr_group_r,
  // status
  input wire [7:0] ovf_status
);
  reg busy_r;
  // busy only from the start pulse, so a done in the fetch cycle is ignored
  always @(posedge clk_sys) begin
    if (!rst_n) busy_r <= 1'b0;
    else if (isr_start_r) busy_r <= 1'b1;
    else if (isr_done) busy_r <= 1'b0;
  end
  function [1:0] grp_of(input [5:0] e);
    case (e)
      6'h08, 6'h09, 6'h17, 6'h18, 6'h19, 6'h1A: grp_of = 2'h0;
      6'h0A, 6'h0B, 6'h15, 6'h16: grp_of = 2'h2;
      default: grp_of = 2'h1;
    endcase
  endfunction
  sequence s_fetch;
    !isr_start_r ##1 isr_start_r;
  endsequence
  sequence s_gap;
    !isr_start_r [*2];
  endsequence
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_one_routine: assert property (isr_start_r |-> !busy_r)
    else $error("second routine started");
  chk_fetch_start: assert property ($rose(isr_active) |-> s_fetch)
    else $error("start not one cycle after fetch");
  chk_done_ends: assert property (isr_done && busy_r |=> !isr_active)
    else $error("active stayed after done");
  chk_restart_gap: assert property (isr_done && busy_r |=> s_gap)
    else $error("restart too soon after done");
  chk_no_preempt:
    assert property (busy_r && !isr_done |=>
      isr_active && $stable(isr_event_r))
    else $error("running routine preempted");
  chk_event_group:
    assert property (isr_start_r |-> isr_group_r == grp_of(isr_event_r))
    else $error("event in wrong group");
  chk_ovf_spare: assert property (ovf_status[7:3] == 5'h00)
    else $error("spare overflow bits set");
  chk_ovf_clear:
    assert property (|($past(ovf_status) & ~ovf_status) |->
      $past(isr_done) || !$past(rst_n))
    else $error("overflow cleared outside return");
  chk_irq_gate:
    assert property (!irq_enable && !isr_active |=> !isr_active)
    else $error("dispatch while disabled");
endmodule // peq_dispatch_monitor
bind peq_dispatch peq_dispatch_monitor i_mon (.clk_sys(clk_sys),
  .rst_n(rst_n), .irq_enable(irq_enable), .isr_done(isr_done),
  .isr_start_r(isr_start_r), .isr_active(isr_active),
  .isr_event_r(isr_event_r), .isr_group_r(isr_group_r),
  .ovf_status(ovf_status));

//--- verification/peq_core_model.sv
// processor core model: one done pulse per routine start
// assumes: svc_len steady while a routine runs
`timescale 1ns/100ps
module peq_core_model (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // dispatcher side
  input wire isr_start_r,
  output reg isr_done,
  // extra routine cycles
  input wire [3:0] svc_len
);
  reg [3:0] cnt_r;
  reg run_r;
  always @(posedge clk_sys) begin
    isr_done <= 1'b0;
    if (!rst_n) run_r <= 1'b0;
    else if (isr_start_r) begin
      run_r <= 1'b1;
      cnt_r <= svc_len;
    end else if (run_r && cnt_r == 4'h0) begin
      isr_done <= 1'b1;
      run_r <= 1'b0;
    end else cnt_r <= cnt_r - 4'h1;
  end
endmodule // peq_core_model

//--- verification/testbench.sv
// self-checking bench for the event queue dispatcher
// assumes: core model answers starts; clock enable dropped only in idle
`timescale 1ns/100ps
module testbench;
  reg clk_sys, rst_n, irq_enable, ce;
  reg [33:0] evt_in;
  reg [3:0] svc_len;
  wire isr_done, isr_start_r, isr_active;
  wire [5:0] isr_event_r;
  wire [1:0] isr_group_r;
  wire [7:0] ovf_status;
  int err_total = 0;
  int n_compared = 0;
  logic [7:0] got[$];
  logic [7:0] exp_q[$];
  peq_dispatch i_peq_dispatch (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .evt_in(evt_in), .irq_enable(irq_enable), .isr_done(isr_done),
    .isr_start_r(isr_start_r), .isr_active(isr_active),
    .isr_event_r(isr_event_r), .isr_group_r(isr_group_r),
    .ovf_status(ovf_status));
  peq_core_model i_peq_core_model (.clk_sys(clk_sys), .rst_n(rst_n),
    .isr_start_r(isr_start_r), .isr_done(isr_done), .svc_len(svc_len));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // log of dispatched {group, event}
  always @(posedge clk_sys)
    if (isr_start_r === 1'b1) got.push_back({isr_group_r, isr_event_r});
  task summarize;
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task check(input string what, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask
  task pulse(input logic [33:0] m);
    @(posedge clk_sys);
    #1 evt_in = m;
    @(posedge clk_sys);
    #1 evt_in = 34'h0;
  endtask
  task wait_for(input int n, input bit idle);
    int k;
    k = 0;
    while ((idle ? isr_active !== 1'b0 : got.size() < n) && k < 1000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 1000) begin
      err_total++;
      $display("Error wait expected below %0d cycles seen %0d", 1000, k);
    end
    #1;
  endtask
  // waits out every expected start, then looks for stray ones
  task drain;
    logic [7:0] seen;
    wait_for(exp_q.size(), 1'b0);
    wait_for(0, 1'b1);
    repeat (4) @(posedge clk_sys);
    #1;
    while (exp_q.size() > 0) begin
      seen = got.size() ? got.pop_front() : 8'hFF;
      check("dispatch", exp_q.pop_front(), seen);
    end
    check("extra", 8'h00, 8'(got.size()));
    got.delete();
  endtask
  task t_group_rank;
    int cm_l[4] = '{8, 9, 23, 24};
    int io_l[16] = '{19, 20, 0, 2, 4, 6, 1, 3, 5, 7, 12, 27, 28, 13, 14, 15};
    int tm_l[4] = '{10, 11, 21, 22};
    irq_enable = 1'b0;
    svc_len = 4'h1;
    pulse({34{1'b1}});
    // staging moves one entry per group per cycle
    repeat (30) @(posedge clk_sys);
    #1 check("ovf", 8'h03, ovf_status);
    foreach (cm_l[i]) exp_q.push_back({2'h0, 6'(cm_l[i])});
    foreach (io_l[i]) exp_q.push_back({2'h1, 6'(io_l[i])});
    foreach (tm_l[i]) exp_q.push_back({2'h2, 6'(tm_l[i])});
    irq_enable = 1'b1;
    wait_for(1, 1'b0);
    check("ovf", 8'h03, ovf_status);
    drain;
    check("ovf", 8'h00, ovf_status);
  endtask
  task t_fifo_order;
    svc_len = 4'hF;
    exp_q = '{8'h47, 8'h1A, 8'h61, 8'h53, 8'h8A};
    pulse(34'h1 << 7);
    wait_for(1, 1'b0);
    pulse(34'h1 << 33);
    pulse(34'h1 << 19);
    pulse(34'h1 << 26);
    pulse(34'h1 << 10);
    drain;
  endtask
  task t_timed_masked;
    irq_enable = 1'b0;
    svc_len = 4'h0;
    repeat (9) pulse(34'h1 << 10);
    repeat (3) @(posedge clk_sys);
    #1 check("ovf", 8'h04, ovf_status);
    repeat (8) exp_q.push_back(8'h8A);
    irq_enable = 1'b1;
    drain;
    check("ovf", 8'h00, ovf_status);
  endtask
  // clock enable low: a staged event waits, nothing is dispatched
  task t_ce_freeze;
    svc_len = 4'h3;
    pulse(34'h1 << 8);
    ce = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 check("frozen", 8'h00, {7'h00, isr_active});
    check("frozen start", 8'h00, 8'(got.size()));
    ce = 1'b1;
    exp_q.push_back(8'h08);
    drain;
  endtask
  initial begin
    rst_n = 1'b0;
    evt_in = 34'h0;
    ce = 1'b1;
    irq_enable = 1'b0;
    svc_len = 4'h0;
    repeat (4) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    t_group_rank;
    t_fifo_order;
    t_ce_freeze;
    t_timed_masked;
    summarize;
  end
  // whole run needs well under 2000 cycles
  initial begin
    #50000;
    err_total++;
    summarize;
  end
endmodule // testbench
